// File: logic/paged_data_address_extension.sv
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
// How it works
// - read page plus low address forms read address
// - write page plus low address forms write address
// - ten-bit read page, nine-bit write page
// - read pages from 0x200 reach program window
// - writes toward program space raise a trap
// - paged access with page zero traps
// - overflow increments page, keeps bit 15 set
// - underflow decrements page, keeps bit 15 set
// - crossings count only for pre/post modify
// - offset, modulo, bit-reverse wrap within page
// - overflow from last pages drops to base
// - overflow from 0x2FF moves to 0x300
// - underflow from 0x001 or 0x200 drops to base
// - underflow from 0x300 moves to 0x2FF
// - only small modifications stay linear
// - read and write pages work independently
// - thirty-two and sixteen megabyte reach
// - both pages reset to 0x001
// - software write of zero leaves page unchanged
module paged_data_address_extension #(
  parameter int ADDR_W = 4 // register bus address width
) (
  input wire logic aclk,                    // system clock
  input wire logic aresetn,                 // synchronous reset, low active
  input wire logic [ADDR_W-1:0] awaddr,     // write address
  input wire logic awvalid,                 // write address valid
  output logic awready,                     // write address ready
  input wire logic [31:0] wdata,            // write data
  input wire logic [3:0] wstrb,             // byte strobes
  input wire logic wvalid,                  // write data valid
  output logic wready,                      // write data ready
  output logic [1:0] bresp,                 // write response
  output logic bvalid,                      // write response valid
  input wire logic bready,                  // write response ready
  input wire logic [ADDR_W-1:0] araddr,     // read address
  input wire logic arvalid,                 // read address valid
  output logic arready,                     // read address ready
  output logic [31:0] rdata,                // read data
  output logic [1:0] rresp,                 // read response
  output logic rvalid,                      // read data valid
  input wire logic rready,                  // read data ready
  input wire logic req_valid,               // address request strobe
  input wire page_pkg::addr_req_t req,      // address request
  output logic resp_valid,                  // answer strobe, one cycle
  output page_pkg::addr_resp_t resp,        // answer
  output logic [9:0] read_page_reg,         // current read page
  output logic [8:0] write_page_reg         // current write page
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [9:0] rpage_q, rpage_d;      // read page
  logic [8:0] wpage_q, wpage_d;      // write page
  logic trap_q, trap_d;              // sticky trap flag
  logic resp_valid_q, resp_valid_d;  // answer strobe
  page_pkg::addr_resp_t resp_q, resp_d; // registered answer

  logic aw_have_q, aw_have_d;        // write address held
  logic w_have_q, w_have_d;          // write data held
  logic [ADDR_W-1:0] aw_q, aw_d;     // held write address
  logic [31:0] wd_q, wd_d;           // held write data
  logic [3:0] ws_q, ws_d;            // held strobes
  logic bvalid_q, bvalid_d;          // write response pending
  logic [1:0] bresp_q, bresp_d;      // write response code
  logic awready_q, awready_d;        // registered ready
  logic wready_q, wready_d;          // registered ready
  logic arready_q, arready_d;        // registered ready
  logic rvalid_q, rvalid_d;          // read data pending
  logic [31:0] rdata_q, rdata_d;     // read data
  logic [1:0] rresp_q, rresp_d;      // read response code

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // merge the low two byte lanes into a page value
  function automatic logic [9:0] merge_page(input logic [9:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [9:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = data[7:0];
    end
    if (strb[1]) begin
      v[9:8] = data[9:8];
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // crossing steps for both pages
  // ---------------------------------------------------------------
  logic [9:0] rstep_page, wstep_page; // pages after a crossing
  logic rstep_ea15, wstep_ea15;       // bit 15 after a crossing

  page_step #(.IS_READ(1'b1)) u_rstep (
    .page(rpage_q),
    .ovf(req.ovf),
    .unf(req.unf),
    .page_nxt(rstep_page),
    .ea15(rstep_ea15)
  );

  page_step #(.IS_READ(1'b0)) u_wstep (
    .page({1'b0, wpage_q}),
    .ovf(req.ovf),
    .unf(req.unf),
    .page_nxt(wstep_page),
    .ea15(wstep_ea15)
  );

  // ---------------------------------------------------------------
  // request classification
  // ---------------------------------------------------------------
  logic crossing;       // pre/post crossing from a paged address
  logic wrapping;       // crossing in a wrap-only mode
  logic [9:0] sel_page; // page used to form the address
  logic [15:0] ea_fix;  // effective address after bit 15 fix-up
  page_pkg::addr_resp_t formed; // formed answer
  logic hw_step;        // page register steps this cycle

  // large offsets can cross more than one page; only one step is taken
  always_comb begin
    crossing = req.ea_orig[page_pkg::EA_PAGED_BIT] &&
               req.mode == page_pkg::MODE_PREPOST && (req.ovf || req.unf);
    wrapping = req.ea_orig[page_pkg::EA_PAGED_BIT] && (req.ovf || req.unf) &&
               (req.mode == page_pkg::MODE_OFFSET || req.mode == page_pkg::MODE_MODULO ||
                req.mode == page_pkg::MODE_BITREV);
    ea_fix = req.ea_mod;
    sel_page = req.write ? {1'b0, wpage_q} : rpage_q;
    if (crossing) begin
      // bit 15 is taken from the table, the page already stepped
      ea_fix[page_pkg::EA_PAGED_BIT] = req.write ? wstep_ea15 : rstep_ea15;
      sel_page = req.write ? wstep_page : rstep_page;
    end else if (wrapping) begin
      ea_fix[page_pkg::EA_PAGED_BIT] = 1'b1;
    end
  end

  addr_form u_form (
    .page(sel_page),
    .ea(ea_fix),
    .write(req.write),
    .ps_target(req.ps_target),
    .resp(formed)
  );

  assign hw_step = req_valid && crossing && !formed.trap;

  // ---------------------------------------------------------------
  // bus write channel
  // ---------------------------------------------------------------
  logic wr_do; // held address and data meet this cycle
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_d = aw_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    // address and data may come in either order
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
      aw_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_have_d = 1'b1;
      wd_d = wdata;
      ws_d = wstrb;
    end
    wr_do = aw_have_d && w_have_d && !bvalid_q;
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_do) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (aw_d == page_pkg::OFS_READ_PAGE || aw_d == page_pkg::OFS_WRITE_PAGE ||
                 aw_d == page_pkg::OFS_STATUS) ? page_pkg::RESP_OKAY : page_pkg::RESP_SLVERR;
    end
    // one write at a time: no new beat on a channel while it holds one or a response is pending
    awready_d = !aw_have_d && !bvalid_d && !wr_do;
    wready_d = !w_have_d && !bvalid_d && !wr_do;
  end

  // ---------------------------------------------------------------
  // pages, flag and answer
  // ---------------------------------------------------------------
  logic [9:0] sw_val; // merged software value
  always_comb begin
    rpage_d = rpage_q;
    wpage_d = wpage_q;
    trap_d = trap_q;
    sw_val = page_pkg::PAGE_ZERO;
    if (hw_step) begin
      if (req.write) begin
        wpage_d = wstep_page[8:0];
      end else begin
        rpage_d = rstep_page;
      end
    end
    // software write wins over a hardware step in the same cycle
    if (wr_do && aw_d == page_pkg::OFS_READ_PAGE) begin
      sw_val = merge_page(rpage_q, wd_d, ws_d);
      if (sw_val != page_pkg::PAGE_ZERO) begin
        rpage_d = sw_val;
      end
    end
    if (wr_do && aw_d == page_pkg::OFS_WRITE_PAGE) begin
      sw_val = merge_page({1'b0, wpage_q}, wd_d, ws_d);
      if (sw_val[8:0] != page_pkg::PAGE_ZERO[8:0]) begin
        wpage_d = sw_val[8:0];
      end
    end
    if (wr_do && aw_d == page_pkg::OFS_STATUS && ws_d[0] && wd_d[page_pkg::STAT_TRAP]) begin
      trap_d = 1'b0;
    end
    // a trap in the clearing cycle is kept
    if (req_valid && formed.trap) begin
      trap_d = 1'b1;
    end
    resp_valid_d = req_valid;
    resp_d = req_valid ? formed : resp_q;
  end

  // ---------------------------------------------------------------
  // bus read channel
  // ---------------------------------------------------------------
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = page_pkg::RESP_OKAY;
      case (araddr)
        page_pkg::OFS_READ_PAGE: begin
          rdata_d = {22'h000000, rpage_q};
        end
        page_pkg::OFS_WRITE_PAGE: begin
          rdata_d = {23'h000000, wpage_q};
        end
        page_pkg::OFS_STATUS: begin
          // shows the block's own state
          rdata_d = {29'h00000000, resp_q.prog, resp_q.ext, trap_q};
        end
        default: begin
          rdata_d = 32'h00000000;
          rresp_d = page_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rpage_q <= page_pkg::PAGE_RESET;
      wpage_q <= page_pkg::PAGE_RESET[8:0];
      trap_q <= 1'b0;
      resp_valid_q <= 1'b0;
      resp_q <= '0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= '0;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= page_pkg::RESP_OKAY;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= page_pkg::RESP_OKAY;
    end else begin
      rpage_q <= rpage_d;
      wpage_q <= wpage_d;
      trap_q <= trap_d;
      resp_valid_q <= resp_valid_d;
      resp_q <= resp_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_q <= aw_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign resp_valid = resp_valid_q;
  assign resp = resp_q;
  assign read_page_reg = rpage_q;
  assign write_page_reg = wpage_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic quiet_sw; // no software write to either page this cycle
  assign quiet_sw = !(wr_do && (aw_d == page_pkg::OFS_READ_PAGE ||
                                aw_d == page_pkg::OFS_WRITE_PAGE));

  sequence s_read_ovf;
    req_valid && !req.write && crossing && req.ovf && quiet_sw;
  endsequence

  AST_RESET_PAGES: assert property (
    !$past(aresetn) |-> rpage_q == page_pkg::PAGE_RESET && wpage_q == page_pkg::PAGE_RESET[8:0])
    else $error("pages not at reset value");
  AST_NEVER_ZERO: assert property (
    rpage_q != page_pkg::PAGE_ZERO && wpage_q != page_pkg::PAGE_ZERO[8:0])
    else $error("page register reached zero");
  AST_PASS_LOW: assert property (
    req_valid && !req.ea_mod[page_pkg::EA_PAGED_BIT] && !crossing && !wrapping
      |=> resp_valid && resp.addr[15:0] == $past(req.ea_mod)
      && resp.addr[23:16] == page_pkg::BASE_UPPER)
    else $error("low half not passed through");
  AST_EXT_READ: assert property (
    req_valid && !req.write && req.mode == page_pkg::MODE_PLAIN && req.ea_mod[15] && !rpage_q[9]
      |=> resp.addr == {$past(rpage_q[8:0]), $past(req.ea_mod[14:0])} && resp.ext)
    else $error("extended read address wrong");
  AST_EXT_WRITE: assert property (
    req_valid && req.write && !req.ps_target && req.mode == page_pkg::MODE_PLAIN && req.ea_mod[15]
      |=> resp.addr == {$past(wpage_q), $past(req.ea_mod[14:0])} && !resp.prog)
    else $error("extended write address wrong");
  AST_PS_WRITE_TRAP: assert property (
    req_valid && req.write && req.ps_target |=> resp.trap && !resp.ext ##1 trap_q)
    else $error("program space write not trapped");
  AST_OVF_STEP: assert property (
    s_read_ovf and (rpage_q < page_pkg::PAGE_EXT_LAST)
      |=> rpage_q == $past(rpage_q) + page_pkg::PAGE_ONE
      && resp.ea[15])
    else $error("overflow did not advance read page");
  AST_PSV_STEP: assert property (
    s_read_ovf and (rpage_q == page_pkg::PAGE_PS_LOW_LAST)
      |=> rpage_q == page_pkg::PAGE_PS_HIGH_FIRST && resp.prog)
    else $error("window overflow not to upper-word page");
  AST_WRAP_KEEP: assert property (
    req_valid && wrapping && quiet_sw |=> $stable(rpage_q) && $stable(wpage_q) && resp.ea[15])
    else $error("wrap mode changed page");
  AST_B_HOLD: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

endmodule

// File: logic/page_pkg.sv
package page_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_READ_PAGE = 4'h0;  // data_read_page
  localparam logic [3:0] OFS_WRITE_PAGE = 4'h4; // data_write_page
  localparam logic [3:0] OFS_STATUS = 4'h8;     // sticky trap flag, last access kind

  // status field positions
  localparam int STAT_TRAP = 0; // sticky, write one to clear
  localparam int STAT_EXT = 1;  // last access went to extended data space
  localparam int STAT_PROG = 2; // last access went to the program window

  // ---------------------------------------------------------------
  // page values
  // ---------------------------------------------------------------
  localparam logic [9:0] PAGE_RESET = 10'h001;     // both pages after reset
  localparam logic [9:0] PAGE_ZERO = 10'h000;      // illegal through paging
  localparam logic [9:0] PAGE_EXT_LAST = 10'h1FF;  // last extended page
  localparam logic [9:0] PAGE_PS_FIRST = 10'h200;  // first lower-word window page
  localparam logic [9:0] PAGE_PS_LOW_LAST = 10'h2FF;
  localparam logic [9:0] PAGE_PS_HIGH_FIRST = 10'h300;
  localparam logic [9:0] PAGE_PS_LAST = 10'h3FF;
  localparam logic [9:0] PAGE_ONE = 10'h001;       // page step
  localparam logic [7:0] BASE_UPPER = 8'h00;       // upper byte of base space
  localparam int EA_PAGED_BIT = 15;                // selects the paged half
  localparam int PS_SEL_BIT = 9;                   // read page program select

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_PLAIN,    // no modification, never crosses
    MODE_PREPOST,  // pre- or post-modified indirect
    MODE_OFFSET,   // register offset
    MODE_MODULO,   // modulo addressing
    MODE_BITREV    // bit-reversed addressing
  } addr_mode_t;

  typedef struct packed {
    logic write;          // access is a write
    logic ps_target;      // write aimed at program space
    addr_mode_t mode;     // how the effective address was made
    logic [15:0] ea_orig; // effective address before modification
    logic [15:0] ea_mod;  // effective address after modification
    logic ovf;            // modification carried past 0xFFFF
    logic unf;            // modification borrowed below 0x8000
  } addr_req_t;

  typedef struct packed {
    logic [23:0] addr;    // extended address to the data bus
    logic [15:0] ea;      // effective address after bit 15 fix-up
    logic ext;            // extended data space access
    logic prog;           // program window read
    logic trap;           // address error trap
  } addr_resp_t;

endpackage

// File: logic/page_step.sv
`timescale 1ns/1ns
// next page and paged-half bit for one page crossing
module page_step #(
  parameter bit IS_READ = 1'b1 // read page knows the program window limits
) (
  input wire logic [9:0] page, // page before the crossing
  input wire logic ovf,        // overflow seen
  input wire logic unf,        // underflow seen
  output logic [9:0] page_nxt, // page after the crossing
  output logic ea15            // value for effective address bit 15
);

  // ---------------------------------------------------------------
  // boundary table
  // ---------------------------------------------------------------
  always_comb begin
    page_nxt = page;
    ea15 = 1'b1;
    if (ovf) begin
      if (page == page_pkg::PAGE_EXT_LAST ||
          (IS_READ && page == page_pkg::PAGE_PS_LAST)) begin
        ea15 = 1'b0;
      end else if (IS_READ && page == page_pkg::PAGE_PS_LOW_LAST) begin
        page_nxt = page_pkg::PAGE_PS_HIGH_FIRST;
      end else begin
        page_nxt = page + page_pkg::PAGE_ONE;
      end
    end else if (unf) begin
      // the write page treats its first page the same way
      if (page == page_pkg::PAGE_RESET ||
          (IS_READ && page == page_pkg::PAGE_PS_FIRST)) begin
        ea15 = 1'b0;
      end else if (IS_READ && page == page_pkg::PAGE_PS_HIGH_FIRST) begin
        page_nxt = page_pkg::PAGE_PS_LOW_LAST;
      end else begin
        page_nxt = page - page_pkg::PAGE_ONE;
      end
    end
  end

endmodule

// File: logic/addr_form.sv
`timescale 1ns/1ns
// builds the 24-bit address and the trap from a page and an address
module addr_form (
  input wire logic [9:0] page,   // selected page
  input wire logic [15:0] ea,    // effective address after fix-up
  input wire logic write,        // access is a write
  input wire logic ps_target,    // write aimed at program space
  output page_pkg::addr_resp_t resp // formed answer
);

  logic paged; // upper half of base space
  assign paged = ea[page_pkg::EA_PAGED_BIT];

  // ---------------------------------------------------------------
  // address and trap
  // ---------------------------------------------------------------
  always_comb begin
    resp.ea = ea;
    // writes have no way into program space
    resp.trap = (write && ps_target) ||
                (paged && page == page_pkg::PAGE_ZERO);
    if (paged) begin
      resp.addr = {page[8:0], ea[14:0]};
    end else begin
      resp.addr = {page_pkg::BASE_UPPER, ea};
    end
    resp.prog = paged && !write && page[page_pkg::PS_SEL_BIT] && !resp.trap;
    resp.ext = paged && !resp.prog && !resp.trap;
  end

endmodule

// File: test/ea_gen_model.sv
`timescale 1ns/1ns
// stand-in for the effective address generator: one request per go pulse
module ea_gen_model (
  input wire logic aclk,              // system clock
  input wire logic go,                // issue cmd at next edge
  input wire page_pkg::addr_req_t cmd, // request to issue
  output logic req_valid,             // one-cycle strobe
  output page_pkg::addr_req_t req     // request, scrambled while idle
);
  // idle cycles flip the payload so a stale request never looks valid
  always_ff @(posedge aclk) begin
    req_valid <= go;
    req <= go ? cmd : ~req;
  end
endmodule

// File: test/paged_data_address_extension_bench.sv
`timescale 1ns/1ns
module paged_data_address_extension_bench;
  logic aclk, aresetn, go, awvalid, wvalid, bready, arvalid, rready, req_valid;
  logic awready, wready, bvalid, arready, rvalid, resp_valid;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r2;
  logic [9:0] read_page_reg, rp, wp, ep, v;
  logic [8:0] write_page_reg;
  logic [15:0] ee;
  logic [9:0] pgs [7] = '{10'h1FF, 10'h2FF, 10'h3FF, 10'h001, 10'h200, 10'h300, 10'h055};
  page_pkg::addr_req_t cmd, req;
  page_pkg::addr_resp_t resp;
  int n_mismatch, compares, seed;
  paged_data_address_extension DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .req_valid, .req, .resp_valid, .resp, .read_page_reg,
    .write_page_reg);
  ea_gen_model gen (.aclk, .go, .cmd, .req_valid, .req);
  initial begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic ck(input bit ok, input string m);
    compares++;
    if (!ok) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // address and data offered together, each released once taken
  task automatic axw(input logic [3:0] a, input logic [31:0] dt);
    logic ad, wd;
    int n;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= dt;
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (bvalid && ad && wd) break;
      if (awready && !ad) begin
        ad = 1;
        awvalid <= 0;
      end
      if (wready && !wd) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    r2 = bresp;
    bready <= 0;
    ck(n < 40, "write answer");
  endtask
  task automatic axr(input logic [3:0] a);
    logic ad;
    int n;
    ad = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (rvalid && ad) break;
      if (arready && !ad) begin
        ad = 1;
        arvalid <= 0;
      end
    end
    d = rdata;
    r2 = rresp;
    rready <= 0;
    ck(n < 40, "read answer");
  endtask
  task automatic setp(input logic [9:0] r, input logic [9:0] w);
    axw(page_pkg::OFS_READ_PAGE, {22'h0, r});
    axw(page_pkg::OFS_WRITE_PAGE, {23'h0, w[8:0]});
    rp = r;
    wp = {1'b0, w[8:0]};
  endtask
  function automatic page_pkg::addr_req_t mk(logic w, logic ps, page_pkg::addr_mode_t md,
                                             logic [15:0] o, int dl);
    page_pkg::addr_req_t c;
    c.write = w;
    c.ps_target = ps;
    c.mode = md;
    c.ea_orig = o;
    c.ea_mod = o + dl[15:0];
    c.ovf = dl > 0 && c.ea_mod < o;
    c.unf = dl < 0 && o[15] && !c.ea_mod[15];
    return c;
  endfunction
  // predict page and address, issue through the generator, compare
  task automatic rq(input page_pkg::addr_req_t c);
    logic [9:0] pg;
    logic x, t;
    logic [23:0] a24;
    pg = c.write ? wp : rp;
    ep = pg;
    ee = c.ea_mod;
    x = c.ea_orig[15] && (c.ovf || c.unf);
    if (x && c.mode == page_pkg::MODE_PREPOST) begin
      if ((c.ovf && (pg == 10'h1FF || pg == 10'h3FF)) ||
          (c.unf && (pg == 10'h001 || pg == 10'h200)))
        ee[15] = 1'b0;
      else begin
        ep = c.ovf ? pg + 10'h001 : pg - 10'h001;
        ee[15] = 1'b1;
      end
    end else if (x && c.mode != page_pkg::MODE_PLAIN) ee[15] = 1'b1;
    t = c.write && c.ps_target && ee[15];
    a24 = ee[15] ? {ep[8:0], ee[14:0]} : {8'h00, ee};
    @(posedge aclk);
    go <= 1;
    cmd <= c;
    @(posedge aclk);
    go <= 0;
    @(posedge aclk);
    @(negedge aclk);
    ck(resp_valid === 1'b1 && resp.trap === t && resp.ea === ee, "strobe, trap or ea");
    if (!c.write && ep[9] && ee[15]) begin
      ck(resp.prog === 1'b1 && resp.ext === 1'b0, "window");
    end else if (!t) begin
      ck(resp.addr === a24, "addr");
      ck(resp.ext === ee[15] && resp.prog === 1'b0, "ext flag");
    end
    if (c.write) wp = ep;
    else rp = ep;
    ck(read_page_reg === rp && write_page_reg === wp[8:0], "pages");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 79;
    {n_mismatch, compares, aresetn, go, awvalid, wvalid, arvalid, bready, rready} = '0;
    {awaddr, araddr, wdata, wstrb, cmd} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    ck(read_page_reg === 10'h001 && write_page_reg === 9'h001, "reset pages");
    axw(page_pkg::OFS_READ_PAGE, 32'h0);
    axr(page_pkg::OFS_READ_PAGE);
    ck(d[9:0] === 10'h001 && r2 === page_pkg::RESP_OKAY, "zero write kept");
    axr(4'hC);
    ck(r2 === page_pkg::RESP_SLVERR, "unmapped");
    foreach (pgs[i]) for (int k = 0; k < 2; k++) begin
      setp(pgs[i], 10'h001);
      rq(mk(0, 0, page_pkg::MODE_PREPOST, k ? 16'h8002 : 16'hFFFE, k ? -4 : 4));
    end
    for (int m = 2; m < 5; m++) rq(mk(0, 0, page_pkg::addr_mode_t'(m), 16'hFFFE, 4));
    setp(10'h001, 10'h1FF);
    rq(mk(1, 0, page_pkg::MODE_PREPOST, 16'hFFFE, 4));
    rq(mk(1, 1, page_pkg::MODE_PLAIN, 16'h9000, 0));
    axr(page_pkg::OFS_STATUS);
    ck(d[2:0] === 3'h1, "trap flag not set");
    axw(page_pkg::OFS_STATUS, 32'h00000001);
    ck(r2 === page_pkg::RESP_OKAY, "status write response");
    axr(page_pkg::OFS_STATUS);
    ck(d[2:0] === 3'h0, "trap flag not cleared");
    axw(4'hC, 32'h00000000);
    ck(r2 === page_pkg::RESP_SLVERR, "unmapped write");
    // random pages and small steps; large steps are not promised linear
    repeat (150) begin
      v = $random(seed);
      d = $random(seed);
      setp(v == 0 ? 10'h001 : v, d[8:0] == 0 ? 10'h001 : d[9:0]);
      d = $random(seed);
      v = d[18:16] % 5;
      rq(mk(d[20], 0, page_pkg::addr_mode_t'(v), d[15:0], v == 0 ? 0 : $random(seed) % 9));
    end
    end_of_test();
  end
  initial begin
    #(40 * 20000);
    n_mismatch++;
    end_of_test();
  end
endmodule
